// ===== src/vbc_pkg.sv
// Purpose: shared constants and types of the bus controller pair
// Assumes: one 200 MHz clock, synchronous active-high reset
// Notes:   every count is in clock cycles unless named _NS
package vbc_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int RST_HOLD_CLK = 6;
  localparam int AS_LEAD_CLK = 2;
  localparam int AS_GAP_CLK = 2;
  localparam int SLV_GAP_CLK = 2;
  localparam int ONB_GAP_CLK = 3;
  localparam int BBSY_MIN_CLK = 2;
  localparam int ACK_RELEASE_NS = 35;
  localparam int ACK_RELEASE_CLK = ACK_RELEASE_NS / CLK_PERIOD_NS;
  // ==========================================================
  // synchroniser layout: as, las, bgin, rel, lbr, bbsy
  localparam int SYNC_W = 6;
  localparam logic [5:0] SYNC_RST = 6'h3B;
  // ==========================================================
  // master strobe sequencer
  typedef enum logic [2:0] {
    M_OFF, M_LEAD, M_CYCLE, M_GAP, M_REL_HI
  } vbc_mst_type;
  // local master sequencer
  typedef enum logic [1:0] {L_IDLE, L_ADDR, L_DATA, L_END} vbc_loc_type;
endpackage : vbc_pkg

// ===== src/vbc_link_if.sv
// Purpose: local-side link between controller and board logic
// Assumes: both ends on CLK
// Notes:   shared open-drain and three-state wires resolved here
interface vbc_link_if (input wire logic CLK);
  // ==========================================================
  // board logic to controller
  logic las_n_loc;
  logic local_data_strobe_in;
  logic local_read_write;
  logic local_bus_request_n;
  logic release_request;
  logic slave_decode_n;
  logic offboard_decode_n;
  logic onboard_decode;
  logic lack_oe_slv;
  logic lberr_oe_slv;
  // controller to board logic
  logic las_n_dev;
  logic las_oe_dev;
  logic lack_oe_dev;
  logic lberr_oe_dev;
  logic onboard_slave_select_n;
  logic bus_buffer_enable_n;
  logic local_master_enable;
  logic data_buffer_enable_n;
  logic bus_data_strobe_enable_n;
  logic data_buffer_direction;
  logic local_bus_grant_n;
  // resolved shared wires
  logic local_addr_strobe_n;
  logic local_ack_n;
  logic local_bus_error_n;
  assign local_addr_strobe_n = las_oe_dev ? las_n_dev : las_n_loc;
  assign local_ack_n = !(lack_oe_dev || lack_oe_slv);
  assign local_bus_error_n = !(lberr_oe_dev || lberr_oe_slv);
  // ==========================================================
  modport dev (
    input local_addr_strobe_n, local_data_strobe_in, local_read_write,
    input local_bus_request_n, release_request, slave_decode_n,
    input offboard_decode_n, onboard_decode, local_ack_n,
    input local_bus_error_n,
    output las_n_dev, las_oe_dev, lack_oe_dev, lberr_oe_dev,
    output onboard_slave_select_n, bus_buffer_enable_n,
    output local_master_enable, data_buffer_enable_n,
    output bus_data_strobe_enable_n, data_buffer_direction,
    output local_bus_grant_n
  );
  modport loc (
    output las_n_loc, local_data_strobe_in, local_read_write,
    output local_bus_request_n, release_request, slave_decode_n,
    output offboard_decode_n, onboard_decode, lack_oe_slv,
    output lberr_oe_slv,
    input local_addr_strobe_n, local_ack_n, local_bus_error_n,
    input onboard_slave_select_n, bus_buffer_enable_n,
    input local_master_enable, data_buffer_enable_n,
    input bus_data_strobe_enable_n, data_buffer_direction,
    input local_bus_grant_n
  );
endinterface : vbc_link_if

// ===== src/vbc_dev.sv
// Purpose: bus controller end: arbitration, strobes, role switching
// Assumes: one clock, synchronous reset, external bus pins split
// Notes:   acknowledge and strobe relays are combinational paths
// Notes on behaviour
// - reset held at least six clocks
// - async inputs sampled, one edge slack allowed
// - decodes valid one edge after strobe seen
// - request bus only while busy is high
// - pass grant on when not taking bus
// - strobe high two clocks between cycles
// - buffer enable after grant, idle strobe, master
// - busy after grant, request dropped next clock
// - busy held two clocks, released on release condition
// - early release: buffers off, strobe high, float
// - direction follows write, reversed as slave
// - data strobe enable per read/write timing
// - relay bus acknowledge and error locally
// - switch to slave, then buffers, then select
// - slave select gap two clocks between cycles
// - onboard slaves answer only when selected
// - relay local answer to bus, end on strobe
// - onboard slaves drop answer quickly
// - switch back to master when slave idle and a local cycle is decoded
// - onboard select, three clock gap, drop on strobe
// - DMA mode mirrors address strobe locally
// - local grant after bus grant and request, DMA mode only
// - select held through block until strobe high
module vbc_dev
  import vbc_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // configuration
  input wire logic DMA_MODE,
  // bus address strobe, three-state
  input wire logic AS_N_I,
  output logic AS_N_O,
  output logic AS_N_OE,
  // arbitration, request and busy open drain, grant chained in to out
  input wire logic BR_N_I,
  output logic BR_N_O,
  output logic BR_N_OE,
  input wire logic BBSY_N_I,
  output logic BBSY_N_O,
  output logic BBSY_N_OE,
  input wire logic BG_IN_N,
  output logic BG_OUT_N,
  // acknowledge, open drain
  input wire logic DTACK_N_I,
  output logic DTACK_N_O,
  output logic DTACK_N_OE,
  input wire logic BERR_N_I,
  output logic BERR_N_O,
  output logic BERR_N_OE,
  // local side
  vbc_link_if.dev LNK
);
  // ==========================================================
  // input synchronisers
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic as_s, las_s, bgin_s, rel_s, lbr_s, bbsy_s;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
    end else begin
      sync1 <= {AS_N_I, LNK.local_addr_strobe_n, BG_IN_N,
                LNK.release_request, LNK.local_bus_request_n, BBSY_N_I};
      sync2 <= sync1;
    end
  end
  assign {as_s, las_s, bgin_s, rel_s, lbr_s, bbsy_s} = sync2;
  // ==========================================================
  // state
  logic br, bbsy, own, bgout_n, vme_en, mast, sel, lbg, lbg_wait;
  logic las_oe, back_q, dsen_w, as_n, as_oe;
  logic [1:0] bbsy_cnt, as_cnt, sel_cnt, sw_step;
  vbc_mst_type mst, next_mst;
  logic want_bus, want_cyc, grant_now, rel_ok, as_change, back_now;
  logic write, dsen, den_m;
  // request source depends on interface type
  assign want_cyc = !las_s && !LNK.offboard_decode_n;
  assign want_bus = DMA_MODE ? !lbr_s : want_cyc;
  assign grant_now = br && !own && !bgin_s;
  assign rel_ok = bgin_s && rel_s && lbr_s;
  assign as_change = (next_mst != mst);
  assign back_now = mast && !las_s && !sel && as_s && sw_step == 2'h0
    && (LNK.onboard_decode || !LNK.offboard_decode_n);
  // ==========================================================
  // arbitration: request, busy, release
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      br <= 1'b0;
      bbsy <= 1'b0;
      own <= 1'b0;
      bbsy_cnt <= 2'h0;
    end else begin
      if (!own && !br && want_bus && bbsy_s && !mast)
        br <= 1'b1;
      if (grant_now) begin
        own <= 1'b1;
        bbsy <= 1'b1;
        bbsy_cnt <= 2'h0;
      end
      if (bbsy && br)
        br <= 1'b0;
      if (own && bbsy_cnt != 2'(BBSY_MIN_CLK))
        bbsy_cnt <= bbsy_cnt + 2'h1;
      if (own && !br && bbsy_cnt == 2'(BBSY_MIN_CLK) && rel_ok
          && !as_change) begin
        own <= 1'b0;
        bbsy <= 1'b0;
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST)
      bgout_n <= 1'b1;
    else
      bgout_n <= !(!bgin_s && !br && !own);
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST || !DMA_MODE || lbr_s) begin
      lbg <= 1'b0;
      lbg_wait <= 1'b0;
    end else if (own || grant_now) begin
      if (as_s || lbg_wait)
        lbg <= 1'b1;
      lbg_wait <= 1'b1;
    end
  end
  // drive local strobe in DMA mode
  always_ff @(posedge CLK) begin
    if (SYS_RST || !DMA_MODE)
      las_oe <= 1'b0;
    else if (!las_oe && bbsy_s && as_s && !lbg)
      las_oe <= 1'b1;
    else if (las_oe && as_s && lbg)
      las_oe <= 1'b0;
  end
  // ==========================================================
  // master address strobe sequencer
  always_comb begin
    next_mst = mst;
    unique case (mst)
      M_OFF:
        if (vme_en && !mast && own && want_cyc)
          next_mst = M_LEAD;
      M_LEAD:
        if (as_cnt == 2'h0)
          next_mst = M_CYCLE;
      M_CYCLE:
        if (las_s)
          next_mst = own ? M_GAP : (vme_en ? M_CYCLE : M_REL_HI);
      M_GAP:
        if (!own)
          next_mst = M_REL_HI;
        else if (as_cnt == 2'h0 && want_cyc)
          next_mst = M_CYCLE;
      M_REL_HI:
        next_mst = M_OFF;
    endcase
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      mst <= M_OFF;
      as_cnt <= 2'h0;
      as_n <= 1'b1;
      as_oe <= 1'b0;
    end else begin
      mst <= next_mst;
      as_n <= (next_mst != M_CYCLE);
      as_oe <= (next_mst != M_OFF);
      if (mst == M_OFF && next_mst == M_LEAD)
        as_cnt <= 2'(AS_LEAD_CLK - 2);
      else if (mst == M_CYCLE && next_mst == M_GAP)
        as_cnt <= 2'(AS_GAP_CLK - 1);
      else if (as_cnt != 2'h0)
        as_cnt <= as_cnt - 2'h1;
    end
  end
  // ==========================================================
  // bus buffer enable and role
  always_ff @(posedge CLK) begin
    if (SYS_RST)
      vme_en <= 1'b0;
    else if (mst == M_CYCLE && las_s && !own)
      vme_en <= 1'b0;
    else if (back_now)
      vme_en <= 1'b0;
    else if (sw_step == 2'h1)
      vme_en <= 1'b1;
    else if (own && !mast && as_s && want_cyc)
      vme_en <= 1'b1;
    else if (!own && !mast && mst != M_CYCLE)
      vme_en <= 1'b0;
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      mast <= 1'b0;
      back_q <= 1'b0;
      sw_step <= 2'h0;
    end else begin
      back_q <= back_now;
      if (!mast && !as_s && mst == M_OFF && !LNK.slave_decode_n
          && !sel) begin
        mast <= 1'b1;
        sw_step <= 2'h1;
      end else if (sw_step != 2'h0)
        sw_step <= (sw_step == 2'h1) ? 2'h2 : 2'h0;
      if (back_q)
        mast <= 1'b0;
    end
  end
  // ==========================================================
  // onboard slave select
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sel <= 1'b0;
      sel_cnt <= 2'h0;
    end else begin
      if (sel_cnt != 2'h0)
        sel_cnt <= sel_cnt - 2'h1;
      if (sel) begin
        if (mast ? as_s : las_s) begin
          sel <= 1'b0;
          sel_cnt <= mast ? 2'(SLV_GAP_CLK - 1) : 2'(ONB_GAP_CLK - 1);
        end
      end else if (sw_step == 2'h2)
        sel <= 1'b1;
      else if (sel_cnt == 2'h0 && sw_step == 2'h0) begin
        if (mast && !as_s && !LNK.slave_decode_n)
          sel <= 1'b1;
        else if (!mast && !las_s && LNK.onboard_decode && !back_q)
          sel <= 1'b1;
      end
    end
  end
  // ==========================================================
  // data path enables
  assign write = !LNK.local_read_write;
  assign den_m = vme_en && !mast && mst == M_CYCLE
    && (write || LNK.local_data_strobe_in);
  // write strobe one clock after buffer
  always_ff @(posedge CLK) begin
    if (SYS_RST)
      dsen_w <= 1'b0;
    else
      dsen_w <= den_m && write;
  end
  assign dsen = mst == M_CYCLE && !LNK.local_addr_strobe_n
    && LNK.local_data_strobe_in && (!write || dsen_w);
  assign LNK.data_buffer_direction = mast ? !write : write;
  assign LNK.data_buffer_enable_n = !(den_m || (mast && sel
    && (write || LNK.local_data_strobe_in)));
  assign LNK.bus_data_strobe_enable_n = !dsen;
  assign LNK.lack_oe_dev = dsen && !DTACK_N_I;
  assign LNK.lberr_oe_dev = dsen && !BERR_N_I;
  assign DTACK_N_OE = mast && sel && LNK.local_data_strobe_in
    && !LNK.local_ack_n;
  assign BERR_N_OE = mast && sel && LNK.local_data_strobe_in
    && !LNK.local_bus_error_n;
  // ==========================================================
  // pin outputs
  assign DTACK_N_O = 1'b0;
  assign BERR_N_O = 1'b0;
  assign BR_N_O = 1'b0;
  assign BBSY_N_O = 1'b0;
  assign BR_N_OE = br;
  assign BBSY_N_OE = bbsy;
  assign BG_OUT_N = bgout_n || BG_IN_N;
  assign AS_N_O = as_n;
  assign AS_N_OE = as_oe;
  assign LNK.las_n_dev = AS_N_I;
  assign LNK.las_oe_dev = las_oe;
  assign LNK.onboard_slave_select_n = !sel;
  assign LNK.bus_buffer_enable_n = !vme_en;
  assign LNK.local_master_enable = mast;
  assign LNK.local_bus_grant_n = !lbg;
endmodule : vbc_dev

// ===== src/vbc_loc.sv
// Purpose: board-side end: reset, decoders, local master, slave
// Assumes: CYC_REQ is a one-cycle pulse on CLK, LBR_REQ and RELEASE are held levels
// Notes:   answers leave the link combinationally with the strobe
module vbc_loc
  import vbc_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  output logic RST_OUT,
  // local master requests
  input wire logic CYC_REQ,
  input wire logic CYC_WRITE,
  input wire logic CYC_OFFBOARD,
  input wire logic CYC_ONBOARD,
  input wire logic LBR_REQ,
  input wire logic RELEASE,
  output logic CYC_DONE,
  output logic CYC_ERR,
  // onboard slave
  input wire logic VME_HIT,
  input wire logic SLV_READY,
  input wire logic SLV_ERROR,
  output logic SLV_ACCESS,
  // controller side
  vbc_link_if.loc LNK
);
  // ==========================================================
  // reset stretcher
  logic [2:0] rst_cnt;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rst_cnt <= 3'(RST_HOLD_CLK);
      RST_OUT <= 1'b1;
    end else begin
      if (rst_cnt != 3'h0)
        rst_cnt <= rst_cnt - 3'h1;
      RST_OUT <= (rst_cnt != 3'h0);
    end
  end
  // ==========================================================
  // local master sequencer
  vbc_loc_type st;
  logic las_n, dsi, rw, off_n, onb, done, err, lbr_n, rel, slv_n;
  logic answered;
  assign answered = !LNK.local_ack_n || !LNK.local_bus_error_n;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st <= L_IDLE;
      las_n <= 1'b1;
      dsi <= 1'b0;
      rw <= 1'b1;
      off_n <= 1'b1;
      onb <= 1'b0;
      done <= 1'b0;
      err <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (st)
        L_IDLE:
          if (CYC_REQ) begin
            las_n <= 1'b0;
            rw <= !CYC_WRITE;
            off_n <= !CYC_OFFBOARD;
            onb <= CYC_ONBOARD;
            st <= L_ADDR;
          end
        L_ADDR: begin
          dsi <= 1'b1;
          st <= L_DATA;
        end
        L_DATA:
          if (answered) begin
            err <= !LNK.local_bus_error_n;
            dsi <= 1'b0;
            las_n <= 1'b1;
            st <= L_END;
          end
        L_END: begin
          done <= 1'b1;
          off_n <= 1'b1;
          onb <= 1'b0;
          st <= L_IDLE;
        end
      endcase
    end
  end
  // ==========================================================
  // request, release and slave decode levels
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      lbr_n <= 1'b1;
      rel <= 1'b0;
      slv_n <= 1'b1;
      SLV_ACCESS <= 1'b0;
    end else begin
      lbr_n <= !LBR_REQ;
      rel <= RELEASE;
      slv_n <= !VME_HIT;
      SLV_ACCESS <= !LNK.onboard_slave_select_n;
    end
  end
  assign CYC_DONE = done;
  assign CYC_ERR = err;
  assign LNK.las_n_loc = las_n;
  assign LNK.local_data_strobe_in = dsi || (!LNK.onboard_slave_select_n
    && LNK.local_master_enable);
  assign LNK.local_read_write = rw;
  assign LNK.local_bus_request_n = lbr_n;
  assign LNK.release_request = rel;
  assign LNK.slave_decode_n = slv_n;
  assign LNK.offboard_decode_n = off_n;
  assign LNK.onboard_decode = onb;
  // answer only when selected and strobed
  assign LNK.lack_oe_slv = !LNK.onboard_slave_select_n
    && LNK.local_data_strobe_in && SLV_READY && !SLV_ERROR;
  assign LNK.lberr_oe_slv = !LNK.onboard_slave_select_n
    && LNK.local_data_strobe_in && SLV_ERROR;
endmodule : vbc_loc

// ===== verification/vbc_link_properties.sv
// Purpose: concurrent checks on the link between the two ends
// Assumes: one clock, synchronous active-high reset
// Notes:   inputs carry the names of the watched signals
module vbc_link_properties (
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // bus side of the controller
  input wire logic BG_IN_N,
  input wire logic BG_OUT_N,
  input wire logic BR_N_OE,
  input wire logic BBSY_N_OE,
  input wire logic AS_N_O,
  input wire logic AS_N_OE,
  input wire logic DTACK_N_I,
  input wire logic BERR_N_I,
  // link signals
  input wire logic local_read_write,
  input wire logic data_buffer_direction,
  input wire logic local_master_enable,
  input wire logic bus_buffer_enable_n,
  input wire logic onboard_slave_select_n,
  input wire logic bus_data_strobe_enable_n,
  input wire logic local_ack_n,
  input wire logic lack_oe_dev,
  input wire logic lberr_oe_dev,
  input wire logic lack_oe_slv,
  input wire logic local_data_strobe_in
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  // ==========================================================
  // steps of the switch into the slave role
  sequence s_slave_steps;
    ##[1:2] !bus_buffer_enable_n ##[1:2] !onboard_slave_select_n;
  endsequence
  a_grant_high: assert property (BG_IN_N |-> BG_OUT_N)
    else $error("grant out low while grant in high");
  a_br_after_busy: assert property ($rose(BBSY_N_OE) |=> !BR_N_OE)
    else $error("request kept after busy taken");
  a_busy_hold: assert property ($rose(BBSY_N_OE) |-> BBSY_N_OE [*2])
    else $error("busy held less than two clocks");
  a_as_lead: assert property (
    $fell(bus_buffer_enable_n) && !local_master_enable
    |-> ##2 (AS_N_OE && !AS_N_O)) else $error("strobe late after buffer");
  a_as_gap: assert property ($rose(AS_N_O) |-> AS_N_O [*2])
    else $error("strobe gap under two clocks");
  a_dir_role: assert property (
    data_buffer_direction == (local_read_write ~^ local_master_enable))
    else $error("data direction wrong for role");
  a_ack_relay: assert property (
    !local_master_enable && !bus_data_strobe_enable_n && !DTACK_N_I
    |-> !local_ack_n) else $error("acknowledge not relayed");
  a_ack_release: assert property (
    DTACK_N_I && BERR_N_I |-> !lack_oe_dev && !lberr_oe_dev)
    else $error("local answer held after bus answer ended");
  a_slave_gate: assert property (
    lack_oe_slv |-> !onboard_slave_select_n && local_data_strobe_in)
    else $error("onboard answer while not selected");
  a_to_slave: assert property ($rose(local_master_enable)
    |-> s_slave_steps) else $error("slave switch steps out of order");
endmodule : vbc_link_properties

// ===== verification/test_vmebus_master_slave_controller.sv
// Purpose: self-checking bench of both controller ends
// Assumes: bench plays bus arbiter, other master and bus slave
// Notes:   open-drain wires resolved from the enables here
module test_vmebus_master_slave_controller;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // stimulus and observation
  logic clk, sys_rst, rst_out, cyc_req, cyc_write, cyc_off, lbr_req;
  logic release_req, vme_hit, slv_ready, bg_in_n, ext_as_n;
  logic ext_ack, ext_err, as_o, as_oe, br_oe, bbsy_oe, bg_out_n;
  logic dtack_oe, berr_oe, cyc_done, cyc_err, slv_access;
  logic as_w, dtack_w, berr_w, cyc_onb;
  int error_cnt = 0;
  int comparisons = 0;
  int i, n, p, k;
  // wired bus lines
  assign as_w = as_oe ? as_o : ext_as_n;
  assign dtack_w = !(dtack_oe || ext_ack);
  assign berr_w = !(berr_oe || ext_err);
  vbc_link_if lnk (.CLK(clk));
  vbc_loc vbc_loc_inst (.CLK(clk), .SYS_RST(sys_rst), .RST_OUT(rst_out),
    .CYC_REQ(cyc_req), .CYC_WRITE(cyc_write), .CYC_OFFBOARD(cyc_off),
    .CYC_ONBOARD(cyc_onb), .LBR_REQ(lbr_req), .RELEASE(release_req),
    .CYC_DONE(cyc_done), .CYC_ERR(cyc_err), .VME_HIT(vme_hit),
    .SLV_READY(slv_ready), .SLV_ERROR(1'b0), .SLV_ACCESS(slv_access),
    .LNK(lnk.loc));
  vbc_dev vbc_dev_inst (.CLK(clk), .SYS_RST(rst_out), .DMA_MODE(1'b0),
    .AS_N_I(as_w), .AS_N_O(as_o), .AS_N_OE(as_oe), .BR_N_I(!br_oe),
    .BR_N_O(), .BR_N_OE(br_oe), .BBSY_N_I(!bbsy_oe), .BBSY_N_O(),
    .BBSY_N_OE(bbsy_oe), .BG_IN_N(bg_in_n), .BG_OUT_N(bg_out_n),
    .DTACK_N_I(dtack_w), .DTACK_N_O(), .DTACK_N_OE(dtack_oe),
    .BERR_N_I(berr_w), .BERR_N_O(), .BERR_N_OE(berr_oe), .LNK(lnk.dev));
  vbc_link_properties vbc_link_properties_inst (.CLK(clk),
    .SYS_RST(rst_out), .BG_IN_N(bg_in_n), .BG_OUT_N(bg_out_n),
    .BR_N_OE(br_oe), .BBSY_N_OE(bbsy_oe), .AS_N_O(as_o), .AS_N_OE(as_oe),
    .DTACK_N_I(dtack_w), .BERR_N_I(berr_w),
    .local_read_write(lnk.local_read_write),
    .data_buffer_direction(lnk.data_buffer_direction),
    .local_master_enable(lnk.local_master_enable),
    .bus_buffer_enable_n(lnk.bus_buffer_enable_n),
    .onboard_slave_select_n(lnk.onboard_slave_select_n),
    .bus_data_strobe_enable_n(lnk.bus_data_strobe_enable_n),
    .local_ack_n(lnk.local_ack_n), .lack_oe_dev(lnk.lack_oe_dev),
    .lberr_oe_dev(lnk.lberr_oe_dev), .lack_oe_slv(lnk.lack_oe_slv),
    .local_data_strobe_in(lnk.local_data_strobe_in));
  // ==========================================================
  // clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // compare and count
  task automatic check(input logic seen, input logic exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %b expected %b", $time, seen, exp);
    end
  endtask : check
  // direction expected of a master cycle
  function automatic logic exp_dir(input logic write);
    return write;
  endfunction : exp_dir
  // settle point after an edge
  task tick;
    @(posedge clk);
    #1;
  endtask : tick
  // verdict and end of run
  task close_out;
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  // ==========================================================
  // one offboard master cycle, acquiring the bus if needed
  task automatic master_cyc(input logic w, input logic e);
    @(posedge clk);
    cyc_req <= 1'b1;
    cyc_write <= w;
    cyc_off <= 1'b1;
    cyc_onb <= 1'b0;
    lbr_req <= 1'b1;
    @(posedge clk);
    cyc_req <= 1'b0;
    if (bbsy_oe !== 1'b1) begin
      for (i = 0; i < 20 && br_oe !== 1'b1; i++) tick();
      check(br_oe, 1'b1);
      @(posedge clk) bg_in_n <= 1'b0;
      for (i = 0; i < 20 && bbsy_oe !== 1'b1; i++) tick();
      check(bbsy_oe, 1'b1);
      tick();
      check(br_oe, 1'b0);
      @(posedge clk) bg_in_n <= 1'b1;
    end
    for (i = 0; i < 30 && !(as_oe === 1'b1 && as_o === 1'b0); i++) tick();
    check(as_o, 1'b0);
    check(lnk.local_master_enable, 1'b0);
    check(lnk.data_buffer_direction, exp_dir(w));
    for (i = 0; i < 20 && lnk.bus_data_strobe_enable_n !== 1'b0; i++)
      tick();
    @(posedge clk);
    ext_ack <= !e;
    ext_err <= e;
    #1;
    check(lnk.local_ack_n, e);
    check(lnk.local_bus_error_n, !e);
    for (i = 0; i < 20 && cyc_done !== 1'b1; i++) tick();
    check(cyc_err, e);
    for (i = 0; i < 20 && lnk.bus_data_strobe_enable_n !== 1'b1; i++)
      tick();
    @(posedge clk);
    ext_ack <= 1'b0;
    ext_err <= 1'b0;
    for (i = 0; i < 20 && as_o !== 1'b1; i++) tick();
    check(as_o, 1'b1);
  endtask : master_cyc
  // give the bus up by request
  task release_bus;
    @(posedge clk);
    release_req <= 1'b1;
    lbr_req <= 1'b0;
    for (i = 0; i < 20 && bbsy_oe !== 1'b0; i++) tick();
    check(bbsy_oe, 1'b0);
    @(posedge clk) release_req <= 1'b0;
  endtask : release_bus
  // another master addresses this board
  task slave_cyc;
    @(posedge clk);
    vme_hit <= 1'b1;
    slv_ready <= 1'b1;
    ext_as_n <= 1'b0;
    for (i = 0; i < 20 && lnk.local_master_enable !== 1'b1; i++) tick();
    check(lnk.local_master_enable, 1'b1);
    for (i = 0; i < 20 && lnk.onboard_slave_select_n !== 1'b0; i++) tick();
    check(lnk.onboard_slave_select_n, 1'b0);
    repeat (6) tick();
    check(lnk.onboard_slave_select_n, 1'b0);
    check(slv_access, 1'b1);
    @(posedge clk);
    ext_as_n <= 1'b1;
    vme_hit <= 1'b0;
    for (i = 0; i < 20 && lnk.onboard_slave_select_n !== 1'b1; i++) tick();
    check(lnk.onboard_slave_select_n, 1'b1);
  endtask : slave_cyc
  // onboard read by the local master, answered by the onboard slave
  task onboard_cyc;
    @(posedge clk);
    cyc_req <= 1'b1;
    cyc_write <= 1'b0;
    cyc_off <= 1'b0;
    cyc_onb <= 1'b1;
    slv_ready <= 1'b1;
    @(posedge clk);
    cyc_req <= 1'b0;
    for (i = 0; i < 20 && lnk.onboard_slave_select_n !== 1'b0; i++) tick();
    check(lnk.onboard_slave_select_n, 1'b0);
    check(lnk.local_master_enable, 1'b0);
    for (i = 0; i < 20 && cyc_done !== 1'b1; i++) tick();
    check(cyc_done, 1'b1);
    check(cyc_err, 1'b0);
    for (i = 0; i < 20 && lnk.onboard_slave_select_n !== 1'b1; i++) tick();
    check(lnk.onboard_slave_select_n, 1'b1);
  endtask : onboard_cyc
  // ==========================================================
  // main sequence
  initial begin
    {cyc_req, cyc_write, cyc_off, lbr_req, release_req} = 5'h00;
    {vme_hit, slv_ready, ext_ack, ext_err} = 4'h0;
    cyc_onb = 1'b0;
    bg_in_n = 1'b1;
    ext_as_n = 1'b1;
    sys_rst = 1'b1;
    n = 0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    void'($urandom(32'hA471943F));
    for (k = 0; k < 12; k++) begin
      tick();
      if (rst_out === 1'b1) n++;
    end
    check(n >= 6, 1'b1);
    check(br_oe, 1'b0);
    // grant passed on when idle
    @(posedge clk) bg_in_n <= 1'b0;
    repeat (4) tick();
    check(bg_out_n, 1'b0);
    @(posedge clk) bg_in_n <= 1'b1;
    #1;
    check(bg_out_n, 1'b1);
    // back-to-back cycles, last ends in bus error
    for (p = 0; p < 2; p++) begin
      for (k = 0; k < 4; k++) master_cyc(1'($urandom()), k == 3);
      release_bus();
      if (p == 0) begin
        slave_cyc();
        onboard_cyc();
      end
    end
    close_out();
  end
  // watchdog against a hang
  initial begin
    #100us;
    error_cnt++;
    close_out();
  end
endmodule : test_vmebus_master_slave_controller
